// File: rtl/eas_pkg.sv
// Shared constants, types and check-code functions for the serial EEPROM front end
package eas_pkg;
   // Memory organisation
   localparam int unsigned MEM_WORDS   = 256;          // Storage locations
   localparam int unsigned DATA_W      = 8;            // Bits per location
   localparam int unsigned ADDR_W      = 8;            // Word address width
   localparam int unsigned CODE_W      = 12;           // Data plus four check bits
   localparam int unsigned PAGE_BYTES  = 8;            // Largest page write
   localparam int unsigned PAGE_IDX_W  = 3;            // Low address bits inside a page
   localparam int unsigned CNT_W       = 4;            // Width of bit and byte counters
   // Addressing byte fields
   localparam int unsigned RW_BIT      = 0;            // Read/write select
   localparam int unsigned CS_LSB      = 1;            // Lowest select bit
   localparam int unsigned CS_MSB      = 3;            // Highest select bit
   localparam int unsigned TYPE_LSB    = 4;            // Lowest type-code bit
   localparam int unsigned TYPE_MSB    = 7;            // Highest type-code bit
   localparam logic [3:0]  BYTE_END    = 4'h8;         // Bit count at end of a byte
   // Reset values
   localparam logic [7:0]  ADDR_RST    = 8'h00;        // Word pointer after reset
   localparam logic [7:0]  IDLE_BYTE   = 8'hFF;        // Sent when nothing is prefetched
   // Erase/write timing
   localparam int unsigned CORE_MHZ    = 100;          // Core clock rate
   localparam int unsigned EW_TIME_US  = 10000;        // Erase/write time per byte
   localparam int unsigned EW_CYCLES   = EW_TIME_US * CORE_MHZ; // Core cycles per byte
   localparam int unsigned EXT_TICKS   = 64;           // Timing-pin edges per byte
   // Engine states at the link
   typedef enum logic [2:0] {
      EAS_IDLE, EAS_DEV, EAS_WADDR, EAS_WDATA, EAS_READ, EAS_IGNORE
   } eas_link_state_t;
   // Erase/write timer states
   typedef enum logic [1:0] {EAS_EW_IDLE, EAS_EW_RUN, EAS_EW_DONE} eas_ew_state_t;

   // Single-error-correcting code: check bits sit at positions 1, 2, 4 and 8
   function automatic logic [11:0] eas_encode(input logic [7:0] d);
      logic [11:0] w;
      int unsigned k;
      w = 12'h000;
      k = 0;
      for (int p = 1; p <= 12; p++) begin
         if ((p & (p - 1)) != 0) begin
            w[p-1] = d[k];
            k++;
         end
      end
      for (int b = 0; b < 4; b++) begin
         for (int p = 1; p <= 12; p++) begin
            if (((p >> b) & 1) == 1 && (p & (p - 1)) != 0) begin
               w[(1 << b) - 1] = w[(1 << b) - 1] ^ w[p-1];
            end
         end
      end
      return w;
   endfunction : eas_encode

   // Syndrome names the failing position; that bit is flipped before extraction
   function automatic logic [7:0] eas_decode(input logic [11:0] w);
      logic [3:0]  syn;
      logic [11:0] c;
      logic [7:0]  d;
      int unsigned k;
      syn = 4'h0;
      for (int p = 1; p <= 12; p++) begin
         if (w[p-1]) begin
            syn = syn ^ 4'(p);
         end
      end
      c = w;
      if (syn != 4'h0 && syn <= 4'hC) begin
         c[syn - 4'h1] = ~c[syn - 4'h1];
      end
      d = 8'h00;
      k = 0;
      for (int p = 1; p <= 12; p++) begin
         if ((p & (p - 1)) != 0) begin
            d[k] = c[p-1];
            k++;
         end
      end
      return d;
   endfunction : eas_decode
endpackage : eas_pkg

// File: rtl/eas_top.sv
// Serial EEPROM slave: address select, page buffer, coded storage and write timer
// Function
// - Addressing byte shifts in most significant first
// - Bits three..one compared with select pins
// - Select pin high reads one, low zero
// - Storage is 256 words of eight bits
// - Byte write and eight-byte page write
// - Internal write timer, optional external timing clock
// - Stored bytes coded, single errors corrected
// - Lowest address bit: one read, zero write
// - No acknowledge while erase/write cycle runs
`timescale 1ns/10ps
module eas_top
   import eas_pkg::*;
#(
   parameter logic [3:0]  DEV_TYPE   = 4'h6,        // Type code; value is arbitrary
   parameter int unsigned EW_COUNT   = eas_pkg::EW_CYCLES, // Core cycles per byte
   parameter int unsigned EXT_COUNT  = eas_pkg::EXT_TICKS  // Pin edges per byte
) (
   // Core clock and reset
   input  wire logic       core_clk_i,
   input  wire logic       reset_n_i,
   // Link clock that oversamples the bus
   input  wire logic       link_clk_i,
   // Two-wire bus
   input  wire logic       scl_i,
   input  wire logic       sda_i,
   output logic            sda_o,
   output logic            sda_oe_n_o,
   // Straps and timing pin
   input  wire logic [2:0] chip_select_pin_i,     // Bit 2 is select pin 2
   input  wire logic       program_time_pin_i,
   input  wire logic       ext_timing_sel_i,
   // Status
   output logic            ew_busy_o
);
   import eas_pkg::*;

   // Reset release, one copy per domain
   logic [1:0] core_rst_q;                         // Core reset synchroniser
   logic [1:0] link_rst_q;                         // Link reset synchroniser
   logic       core_rst_n;                         // Core reset copy
   logic       link_rst_n;                         // Link reset copy
   always_ff @(posedge core_clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         core_rst_q <= 2'h0;
      end else begin
         core_rst_q <= {core_rst_q[0], 1'b1};
      end
   end
   always_ff @(posedge link_clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         link_rst_q <= 2'h0;
      end else begin
         link_rst_q <= {link_rst_q[0], 1'b1};
      end
   end
   assign core_rst_n = core_rst_q[1];
   assign link_rst_n = link_rst_q[1];

   // ---------------- Link domain ----------------
   logic [2:0]  scl_q;                             // Stage 0 synchronises, stage 2 is history
   logic [2:0]  sda_q;                             // Same for data
   logic [2:0]  cs_meta;                           // First stage of strap sync
   logic [2:0]  cs_s;                              // Select straps as levels
   logic        ack_meta;                          // First stage of timer answer
   logic        ack_s;                             // Timer answer in link domain
   logic        ew_ack;                            // Timer answer, driven in core domain
   // Bus pins pass two flops; edges compare stages 1 and 2 only
   always_ff @(posedge link_clk_i or negedge link_rst_n) begin
      if (!link_rst_n) begin
         scl_q    <= 3'h7;
         sda_q    <= 3'h7;
         cs_meta  <= 3'h0;
         cs_s     <= 3'h0;
         ack_meta <= 1'b0;
         ack_s    <= 1'b0;
      end else begin
         scl_q    <= {scl_q[1:0], scl_i};
         sda_q    <= {sda_q[1:0], sda_i};
         cs_meta  <= chip_select_pin_i;
         cs_s     <= cs_meta;
         ack_meta <= ew_ack;
         ack_s    <= ack_meta;
      end
   end

   logic scl_rise, scl_fall, start_det, stop_det, sda_s;
   assign sda_s     = sda_q[1];
   assign scl_rise  = scl_q[1] & ~scl_q[2];
   assign scl_fall  = ~scl_q[1] & scl_q[2];
   assign start_det = scl_q[1] & scl_q[2] & ~sda_q[1] & sda_q[2];
   assign stop_det  = scl_q[1] & scl_q[2] & sda_q[1] & ~sda_q[2];

   eas_link_state_t state;                         // Engine state
   logic [7:0]       shreg;                        // Receive and transmit shifter
   logic [3:0]       bit_cnt;                      // Rising edges in this byte
   logic             ack_slot;                     // Inside the ninth clock
   logic             drive_low;                    // Pulling the data line
   logic             mack;                         // Master answered a read byte
   logic [7:0]       cur_addr;                     // Word pointer
   logic [3:0]       wcount;                       // Data bytes in page buffer
   logic [7:0]       page_buf [PAGE_BYTES];        // Page data awaiting commit
   logic [7:0]       page_vld;                     // Filled page slots
   logic             ew_req;                       // Commit request to the timer
   logic [3:0]       ew_bytes;                     // Bytes in the committed page
   logic             link_busy;                    // Cycle pending or running
   logic             byte_end, dev_match, commit, flush, pop;
   logic [7:0]       head;                         // Buffer output word
   logic             head_vld;                     // Buffer output valid

   assign link_busy = ew_req | ack_s;
   assign byte_end  = scl_fall & (bit_cnt == BYTE_END) & ~ack_slot
                      & (state != EAS_IDLE) & (state != EAS_IGNORE);
   assign dev_match = (shreg[TYPE_MSB:TYPE_LSB] == DEV_TYPE)
                      & (shreg[CS_MSB:CS_LSB] == cs_s)
                      & ~link_busy;
   assign flush     = byte_end & (state == EAS_DEV) & dev_match & shreg[RW_BIT];
   assign pop       = scl_fall & ack_slot & (state == EAS_READ) & mack;
   assign commit    = stop_det & (state == EAS_WDATA) & (wcount != 4'h0);

   // Bus engine: framing, byte decisions, acknowledge and transmit
   always_ff @(posedge link_clk_i or negedge link_rst_n) begin
      if (!link_rst_n) begin
         state     <= EAS_IDLE;
         shreg     <= 8'h00;
         bit_cnt   <= 4'h0;
         ack_slot  <= 1'b0;
         drive_low <= 1'b0;
         mack      <= 1'b0;
         cur_addr  <= ADDR_RST;
         wcount    <= 4'h0;
         page_vld  <= 8'h00;
      end else if (start_det) begin
         // Any start reopens addressing and drops an unfinished page
         state     <= EAS_DEV;
         bit_cnt   <= 4'h0;
         ack_slot  <= 1'b0;
         drive_low <= 1'b0;
         wcount    <= 4'h0;
         page_vld  <= 8'h00;
      end else if (stop_det) begin
         state     <= EAS_IDLE;
         drive_low <= 1'b0;
         page_vld  <= 8'h00;
      end else if (byte_end) begin
         ack_slot  <= 1'b1;
         drive_low <= 1'b0;
         unique case (state)
            EAS_DEV: begin
               if (!dev_match) begin
                  state <= EAS_IGNORE;
               end else if (shreg[RW_BIT]) begin
                  state     <= EAS_READ;
                  drive_low <= 1'b1;
                  mack      <= 1'b1;
               end else begin
                  state     <= EAS_WADDR;
                  drive_low <= 1'b1;
               end
            end
            EAS_WADDR: begin
               cur_addr  <= shreg;
               state     <= EAS_WDATA;
               drive_low <= 1'b1;
            end
            EAS_WDATA: begin
               if (wcount == 4'(PAGE_BYTES)) begin
                  state <= EAS_IGNORE;
               end else begin
                  // Only the in-page bits advance, so a page wraps on itself
                  page_buf[cur_addr[2:0]] <= shreg;
                  page_vld[cur_addr[2:0]] <= 1'b1;
                  cur_addr[2:0] <= cur_addr[2:0] + 3'h1;
                  wcount    <= wcount + 4'h1;
                  drive_low <= 1'b1;
               end
            end
            default: begin
               // Read: let go of the line so the master can answer
               drive_low <= 1'b0;
            end
         endcase
      end else if (scl_rise && state != EAS_IDLE && state != EAS_IGNORE) begin
         if (ack_slot) begin
            if (state == EAS_READ) begin
               mack <= ~sda_s;
            end
         end else begin
            bit_cnt <= bit_cnt + 4'h1;
            if (state != EAS_READ) begin
               shreg <= {shreg[6:0], sda_s};
            end
         end
      end else if (scl_fall && ack_slot) begin
         ack_slot  <= 1'b0;
         bit_cnt   <= 4'h0;
         drive_low <= 1'b0;
         if (pop) begin
            // Next byte leaves the buffer; pointer counts bytes really sent
            shreg     <= head_vld ? head : IDLE_BYTE;
            drive_low <= head_vld ? ~head[7] : 1'b0;
            cur_addr  <= cur_addr + 8'h01;
         end else if (state == EAS_READ) begin
            state <= EAS_IGNORE;
         end
      end else if (scl_fall && state == EAS_READ && bit_cnt != 4'h0) begin
         shreg     <= {shreg[6:0], 1'b0};
         drive_low <= ~shreg[6];
      end
   end

   // Coded storage; the filled slots of a page are written together when the stop ends a write of at most eight bytes
   logic [CODE_W-1:0] mem [MEM_WORDS];                        // Coded words
   always_ff @(posedge link_clk_i) begin
      if (commit) begin
         for (int i = 0; i < PAGE_BYTES; i++) begin
            if (page_vld[i]) begin
               mem[{cur_addr[7:3], 3'(i)}] <= eas_encode(page_buf[i]);
            end
         end
      end
   end

   // Four-phase request to the timer; held until its answer arrives
   always_ff @(posedge link_clk_i or negedge link_rst_n) begin
      if (!link_rst_n) begin
         ew_req   <= 1'b0;
         ew_bytes <= 4'h0;
      end else if (commit && !link_busy) begin
         ew_req   <= 1'b1;
         ew_bytes <= wcount;
      end else if (ack_s) begin
         ew_req   <= 1'b0;
      end
   end

   // Prefetch reader feeding a two-entry buffer; stalls while it is full
   logic [7:0] pf_addr;                                       // Next word to fetch
   logic       pf_on;                                         // Fetching enabled
   logic [7:0] fifo [2];                                      // Buffer words
   logic       wr_ptr, rd_ptr;                                // Buffer pointers
   logic [1:0] fill;                                          // Words held
   logic       in_valid, in_ready, out_ready;
   logic [7:0] in_data;
   assign in_valid  = pf_on & (state == EAS_READ);
   assign in_ready  = (fill != 2'h2);
   assign in_data   = eas_decode(mem[pf_addr]);
   assign head_vld  = (fill != 2'h0);
   assign head      = fifo[rd_ptr];
   assign out_ready = pop;
   always_ff @(posedge link_clk_i or negedge link_rst_n) begin
      if (!link_rst_n) begin
         pf_addr <= ADDR_RST;
         pf_on   <= 1'b0;
         wr_ptr  <= 1'b0;
         rd_ptr  <= 1'b0;
         fill    <= 2'h0;
      end else if (flush) begin
         // Words fetched ahead of a new read are stale
         pf_addr <= cur_addr;
         pf_on   <= 1'b1;
         wr_ptr  <= 1'b0;
         rd_ptr  <= 1'b0;
         fill    <= 2'h0;
      end else begin
         if (in_valid && in_ready) begin
            fifo[wr_ptr] <= in_data;
            wr_ptr       <= ~wr_ptr;
            pf_addr      <= pf_addr + 8'h01;
         end
         if (out_ready && head_vld) begin
            rd_ptr <= ~rd_ptr;
         end
         fill <= fill + 2'((in_valid && in_ready) ? 1 : 0)
                      - 2'((out_ready && head_vld) ? 1 : 0);
         if (state == EAS_IDLE) begin
            pf_on <= 1'b0;
         end
      end
   end

   // Open-drain data pin: only ever pulls low
   assign sda_o      = 1'b0;
   assign sda_oe_n_o = ~drive_low;

   // ---------------- Core domain ----------------
   logic          req_meta, req_s;                            // Request crossing
   logic [1:0]    ptc_q;                                      // Timing pin sync
   logic          ptc_last;                                   // Timing pin history
   logic [1:0]    sel_q;                                      // Timing mode sync
   eas_ew_state_t ew_state;                                   // Timer state
   logic [31:0]   tick_cnt;                                   // Time within a byte
   logic [3:0]    bytes_left;                                 // Bytes still to time
   logic          tick, tick_last;
   always_ff @(posedge core_clk_i or negedge core_rst_n) begin
      if (!core_rst_n) begin
         req_meta <= 1'b0;
         req_s    <= 1'b0;
         ptc_q    <= 2'h0;
         ptc_last <= 1'b0;
         sel_q    <= 2'h0;
      end else begin
         req_meta <= ew_req;
         req_s    <= req_meta;
         ptc_q    <= {ptc_q[0], program_time_pin_i};
         ptc_last <= ptc_q[1];
         sel_q    <= {sel_q[0], ext_timing_sel_i};
      end
   end
   // External mode counts pin edges, internal mode counts core cycles
   assign tick      = sel_q[1] ? (ptc_q[1] & ~ptc_last) : 1'b1;
   assign tick_last = tick_cnt == (sel_q[1] ? 32'(EXT_COUNT - 1) : 32'(EW_COUNT - 1));

   // Erase/write timer; byte count is stable while the request is high
   always_ff @(posedge core_clk_i or negedge core_rst_n) begin
      if (!core_rst_n) begin
         ew_state   <= EAS_EW_IDLE;
         ew_ack     <= 1'b0;
         tick_cnt   <= 32'h0000_0000;
         bytes_left <= 4'h0;
      end else begin
         unique case (ew_state)
            EAS_EW_IDLE: begin
               if (req_s) begin
                  ew_state   <= EAS_EW_RUN;
                  bytes_left <= ew_bytes;
                  tick_cnt   <= 32'h0000_0000;
               end
            end
            EAS_EW_RUN: begin
               if (tick) begin
                  if (!tick_last) begin
                     tick_cnt <= tick_cnt + 32'h0000_0001;
                  end else if (bytes_left <= 4'h1) begin
                     ew_state <= EAS_EW_DONE;
                     ew_ack   <= 1'b1;
                  end else begin
                     tick_cnt   <= 32'h0000_0000;
                     bytes_left <= bytes_left - 4'h1;
                  end
               end
            end
            EAS_EW_DONE: begin
               if (!req_s) begin
                  ew_state <= EAS_EW_IDLE;
                  ew_ack   <= 1'b0;
               end
            end
         endcase
      end
   end
   assign ew_busy_o = (ew_state != EAS_EW_IDLE);

   // ---------------- Checks ----------------
   chk_msb_first: assert property (@(posedge link_clk_i) disable iff (!link_rst_n)
      scl_rise && !ack_slot && !start_det && !stop_det && state == EAS_DEV
      |=> shreg[0] == $past(sda_s))
      else $error("addressing bit not shifted in at the low end");
   chk_cs_mismatch: assert property (@(posedge link_clk_i) disable iff (!link_rst_n)
      byte_end && state == EAS_DEV && shreg[CS_MSB:CS_LSB] != cs_s
      |=> !drive_low [*2])
      else $error("select mismatch was acknowledged");
   chk_cs_level: assert property (@(posedge link_clk_i) disable iff (!link_rst_n)
      ##2 cs_s == $past(chip_select_pin_i, 2))
      else $error("select strap level not followed");
   chk_addr_wrap: assert property (@(posedge link_clk_i) disable iff (!link_rst_n)
      pop && !start_det && cur_addr == 8'hFF |=> cur_addr == 8'h00)
      else $error("word pointer did not wrap to zero");
   chk_page_limit: assert property (@(posedge link_clk_i) disable iff (!link_rst_n)
      byte_end && state == EAS_WDATA && wcount == 4'h8
      |=> state == EAS_IGNORE && !drive_low && wcount == 4'h8)
      else $error("ninth page byte was taken");
   chk_ew_timed: assert property (@(posedge core_clk_i) disable iff (!core_rst_n)
      $rose(ew_ack) |-> $past(ew_state) == EAS_EW_RUN && $past(tick_last) && $past(tick))
      else $error("write cycle ended before its time");
   logic [11:0] flip_word;
   assign flip_word = mem[pf_addr] ^ (12'h001 << pf_addr[3:0]);
   chk_ecc_single: assert property (@(posedge link_clk_i) disable iff (!link_rst_n)
      // Case equality: words never written read as unknown on both sides
      in_valid && in_ready && pf_addr[3:0] < 4'hC |-> eas_decode(flip_word) === in_data)
      else $error("single-bit error not corrected");
   chk_rw_read: assert property (@(posedge link_clk_i) disable iff (!link_rst_n)
      byte_end && state == EAS_DEV && dev_match
      |=> (state == EAS_READ) == $past(shreg[RW_BIT]) && drive_low)
      else $error("direction bit not honoured");
   chk_busy_nack: assert property (@(posedge link_clk_i) disable iff (!link_rst_n)
      byte_end && state == EAS_DEV && link_busy |=> state == EAS_IGNORE && !drive_low)
      else $error("acknowledged while write cycle pending");
   chk_ignore_quiet: assert property (@(posedge link_clk_i) disable iff (!link_rst_n)
      state == EAS_IGNORE |-> sda_oe_n_o)
      else $error("data line driven while ignoring");
endmodule : eas_top

// File: testbench/eas_bus_master.sv
// Two-wire bus master model: open-drain clock and data with byte tasks
`timescale 1ns/10ps
module eas_bus_master (
   // Resolved data line
   input  wire logic sda_wire_i,
   // Driven levels, high means released to the pull-up
   output logic      scl_o,
   output logic      sda_drv_o
);
   // Quarter bit; slow enough for the oversampler to see every level
   localparam int Q = 75;
   initial begin
      scl_o     = 1'b1;
      sda_drv_o = 1'b1;
   end
   // Start, or repeated start from clock low
   task automatic start_cond();
      sda_drv_o = 1'b1;
      #(2*Q);
      scl_o = 1'b1;
      #(2*Q);
      sda_drv_o = 1'b0;
      #(2*Q);
      scl_o = 1'b0;
   endtask : start_cond
   // Stop leaves both lines released
   task automatic stop_cond();
      #Q;
      sda_drv_o = 1'b0;
      #Q;
      scl_o = 1'b1;
      #(2*Q);
      sda_drv_o = 1'b1;
      #(2*Q);
   endtask : stop_cond
   // Nine clocks; data changes a quarter after the fall so it never reads as start or stop
   task automatic xfer(input logic [8:0] tx, output logic [8:0] rx);
      for (int i = 8; i >= 0; i--) begin
         #Q;
         sda_drv_o = tx[i];
         #Q;
         scl_o = 1'b1;
         #(2*Q);
         rx[i] = sda_wire_i;
         scl_o = 1'b0;
      end
   endtask : xfer
endmodule : eas_bus_master

// File: testbench/eas_top_tb.sv
// Self-checking bench for the serial EEPROM front end
`timescale 1ns/10ps
module eas_top_tb;
   import eas_pkg::*;
   localparam logic [3:0] TYPE_CODE = 4'h6; // Arbitrary type code
   localparam int         EW_N      = 600;  // Shortened per-byte write time
   logic       core_clk, link_clk, reset_n, scl, mdrv, sda_o, sda_oe_n, ptp, ext_sel, busy;
   logic [2:0] cs;
   logic [7:0] wa;
   logic [7:0] mem_exp [256]; // Expected storage contents
   logic [8:0] rx;
   int         fails    = 0;
   int         compares = 0;
   wire        sda_wire = mdrv & (sda_oe_n | sda_o); // Pull-up wins when all release
   eas_top #(.DEV_TYPE(TYPE_CODE), .EW_COUNT(EW_N), .EXT_COUNT(4)) dut (
      .core_clk_i(core_clk), .reset_n_i(reset_n), .link_clk_i(link_clk), .scl_i(scl),
      .sda_i(sda_wire), .sda_o(sda_o), .sda_oe_n_o(sda_oe_n), .chip_select_pin_i(cs),
      .program_time_pin_i(ptp), .ext_timing_sel_i(ext_sel), .ew_busy_o(busy));
   eas_bus_master m (.sda_wire_i(sda_wire), .scl_o(scl), .sda_drv_o(mdrv));
   // Core clock 10 ns, link clock 12 ns with unrelated phase
   initial begin
      core_clk = 1'b0;
      forever #5 core_clk = ~core_clk;
   end
   initial begin
      link_clk = 1'b0;
      #3.7;
      forever #6 link_clk = ~link_clk;
   end
   task automatic check(input logic [8:0] got, input logic [8:0] exp);
      compares++;
      if (got !== exp) begin
         fails++;
         $display("ERROR time %0t got %h expected %h", $time, got, exp);
      end
   endtask : check
   task automatic tally_and_finish();
      $display("Comparisons %0d, mismatches %0d", compares, fails);
      if (fails == 0 && compares > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask : tally_and_finish
   // Addressing byte; ack is the expected acknowledge
   task automatic address(input logic [3:0] ty, input logic [2:0] sel, input logic rd,
                          input logic ack);
      m.start_cond();
      m.xfer({ty, sel, rd, 1'b1}, rx);
      check(9'(rx[0]), 9'(!ack));
   endtask : address
   // Write n bytes, then watch the erase/write busy window
   task automatic write(input logic [7:0] a, input int n);
      logic [7:0] d;
      address(TYPE_CODE, cs, 1'b0, 1'b1);
      m.xfer({a, 1'b1}, rx);
      check(9'(rx[0]), 9'h000);
      for (int i = 0; i < n; i++) begin
         d = 8'($urandom);
         mem_exp[{a[7:3], 3'(a[2:0] + i)}] = d; // Slot wraps inside the page
         m.xfer({d, 1'b1}, rx);
         check(9'(rx[0]), 9'h000);
      end
      m.stop_cond();
      repeat (20) @(posedge core_clk);
      address(TYPE_CODE, cs, 1'b0, 1'b0);
      m.stop_cond();
      // Lands a few cycles before the internal timer may end at the earliest
      repeat (n * EW_N - 400 + (ext_sel ? 300 : 0)) @(posedge core_clk);
      #1 check(9'(busy), 9'h001);
      // External mode: four rising pin edges per byte end the cycle
      for (int i = 0; ext_sel && i < 8 * n; i++) begin
         repeat (10) @(posedge core_clk);
         #1 ptp = ~ptp;
      end
      // Only the handshake back to the link may add cycles after the timer
      for (int t = 0; busy !== 1'b0 && t < 40; t++) @(posedge core_clk);
      #1 check(9'(busy), 9'h000);
   endtask : write
   // Random read of n bytes after a dummy write sets the pointer
   task automatic read(input logic [7:0] a, input int n);
      address(TYPE_CODE, cs, 1'b0, 1'b1);
      m.xfer({a, 1'b1}, rx);
      check(9'(rx[0]), 9'h000);
      address(TYPE_CODE, cs, 1'b1, 1'b1);
      for (int i = 0; i < n; i++) begin
         m.xfer({8'hFF, i == n - 1}, rx);
         check({1'b0, rx[8:1]}, {1'b0, mem_exp[8'(a + i)]});
      end
      m.stop_cond();
   endtask : read
   initial begin
      reset_n = 1'b0;
      ptp     = 1'b0;
      ext_sel = 1'b0;
      cs      = 3'h0;
      void'($urandom(92728));
      repeat (10) @(posedge core_clk);
      #1 reset_n = 1'b1;
      repeat (20) @(posedge core_clk);
      #1 cs = 3'($urandom);
      for (int s = 0; s < 8; s++) begin
         address(TYPE_CODE, 3'(s), 1'b0, 3'(s) == cs);
         m.stop_cond();
      end
      address(~TYPE_CODE, cs, 1'b0, 1'b0);
      m.stop_cond();
      wa = 8'($urandom);
      write(wa, 1);
      read(wa, 1);
      // Top page, so that a later read walks the pointer through 255
      wa = {5'h1F, 3'($urandom)};
      write(wa, 8);
      read({wa[7:3], 3'h0}, 8);
      // Nine data bytes: the ninth is refused and nothing is programmed
      address(TYPE_CODE, cs, 1'b0, 1'b1);
      m.xfer({8'hF8, 1'b1}, rx);
      for (int i = 0; i < 9; i++) begin
         m.xfer({8'($urandom), 1'b1}, rx);
         check(9'(rx[0]), 9'(i == 8));
      end
      m.stop_cond();
      repeat (20) @(posedge core_clk);
      #1 check(9'(busy), 9'h000);
      read(8'hFF, 1);
      @(posedge core_clk);
      #1 ext_sel = 1'b1;
      wa = 8'($urandom);
      write(wa, 1);
      read(wa, 1);
      tally_and_finish();
   end
   // Watchdog well beyond the expected run length
   initial begin
      #500000;
      fails++;
      tally_and_finish();
   end
endmodule : eas_top_tb
